// [src/dsr_status_regs.sv]
// Host-visible status bank of the bitstream de-multiplexer: counters,
// picture status snapshot, spare byte queue, control and reset bits.
// Assumes host strobes are synchronous to CLK and the decoder core
// delivers its events as one-cycle pulses.
//
// Overview of operation
// - Counters at 4, 5 and 9 count frames, filled frames, lock losses.
// - Picture status at 10..13: reference, info, two spare bytes; group queue head at 14.
// - Info bits 5..2 show split, camera, freeze, format; bits 1:0 read one.
// - Info bits 7 and 6 flag spare bytes two and one; reading clears.
// - Visible picture copy holds during a read and 32 clocks after.
// - Reads at 4..9 or 10..13 freeze that whole group for 32 clocks.
// - Only two picture spare bytes kept per picture; more are dropped.
// - Twelve-entry group spare queue; status bit shows it non-empty.
// - Hardware reset clears status, counters and pointers.
// - Reset sets control A video hold and control B bits 0, 4, 5.
// - Reset state re-locks, corrects two-bit errors, FEC framing on.
// - Reset marks macroblock 33 of group 12 as last sent.
// - Control A bit 7 clears status and restarts decoder, corrector, alignment.
// - Restart leaves the macroblock generator untouched.
// - Control A bit 6 resets external buffer read and write pointers.
// - Control B has two clear bits: lock loss counter, other counters.
// - Control B bit 6 clears lock loss count, bit 7 the rest.
// - Counters saturate and hold steady while read.
`timescale 1ns/10ps
`default_nettype none
`include "dsr_consts.svh"
module dsr_status_regs #(
   parameter int CNT_W    = 8,
   parameter int GS_DEPTH = `DSR_GS_DEPTH
) (
   input  wire logic       CLK,
   input  wire logic       RST,
   input  wire logic       CE,
   input  wire logic [3:0] HA,
   input  wire logic [7:0] HD_IN,
   output logic      [7:0] HD_OUT,
   output logic            HD_OE,
   input  wire logic       CEN_N,
   input  wire logic       RD_N,
   input  wire logic       WR_N,
   input  wire logic [5:0] CNT_EV,
   input  wire logic       PIC_LOAD,
   input  wire logic [7:0] PIC_TREF,
   input  wire logic [3:0] PIC_FLAGS,
   input  wire logic       PS_VLD,
   input  wire logic [7:0] PS_BYTE,
   input  wire logic       GS_VLD,
   input  wire logic [7:0] GS_BYTE,
   input  wire logic       FRZ_ACTIVE,
   input  wire logic       BUF_FULL,
   input  wire logic       BUF_EMPTY,
   input  wire logic [3:0] LOCK_EV,
   input  wire logic       MB_SENT,
   input  wire logic [3:0] MB_GOB,
   input  wire logic [5:0] MB_NUM,
   output logic      [7:0] CTRL_A,
   output logic      [7:0] CTRL_B,
   output logic            RESTART,
   output logic            BUF_PTR_CLR,
   output logic            GS_FULL,
   output logic      [3:0] LAST_GOB,
   output logic      [5:0] LAST_MB
);
   // ----------------------------------------
   // Host strobe decode
   // ----------------------------------------
   logic       rd_act;
   logic       rd_act_q;
   logic       wr_act;
   logic       wr_act_q;
   logic [3:0] rd_adr_q;
   logic       rd_end;
   logic       wr_take;
   logic       in_cnt;
   logic       in_pic;

   assign rd_act  = !CEN_N && !RD_N;
   assign wr_act  = !CEN_N && !WR_N;
   assign rd_end  = rd_act_q && !rd_act;
   assign wr_take = wr_act && !wr_act_q;
   assign in_cnt  = (HA >= `DSR_ADR_CNT_LO) && (HA <= `DSR_ADR_CNT_HI);
   assign in_pic  = (HA >= `DSR_ADR_TREF) && (HA <= `DSR_ADR_PS2);
   assign HD_OE   = rd_act;

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         rd_act_q <= 1'b0;
         wr_act_q <= 1'b0;
         rd_adr_q <= '0;
      end
      else if (CE)
      begin
         rd_act_q <= rd_act;
         wr_act_q <= wr_act;
         if (rd_act)
         begin
            rd_adr_q <= HA;
         end
      end
   end

   // ----------------------------------------
   // Control registers and software resets
   // ----------------------------------------
   logic [5:0] cta_q;
   logic [5:0] ctb_q;
   logic       lclr_q;
   logic       oclr_q;

   assign CTRL_A = {2'b00, cta_q};
   assign CTRL_B = {2'b00, ctb_q};

   // Clear and restart bits act once and read back as zero
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         cta_q       <= 6'(`DSR_CTA_RST);
         ctb_q       <= 6'(`DSR_CTB_RST);
         RESTART     <= 1'b0;
         BUF_PTR_CLR <= 1'b0;
         lclr_q      <= 1'b0;
         oclr_q      <= 1'b0;
      end
      else if (CE)
      begin
         RESTART     <= wr_take && (HA == `DSR_ADR_CTA) && HD_IN[`DSR_CTA_RSTRT];
         BUF_PTR_CLR <= wr_take && (HA == `DSR_ADR_CTA) && HD_IN[`DSR_CTA_BCLR];
         lclr_q      <= wr_take && (HA == `DSR_ADR_CTB) && HD_IN[`DSR_CTB_LCLR];
         oclr_q      <= wr_take && (HA == `DSR_ADR_CTB) && HD_IN[`DSR_CTB_OCLR];
         if (wr_take && (HA == `DSR_ADR_CTA))
         begin
            cta_q <= HD_IN[5:0];
         end
         if (wr_take && (HA == `DSR_ADR_CTB))
         begin
            ctb_q <= HD_IN[5:0];
         end
      end
   end

   // ----------------------------------------
   // Macroblock position tracker
   // ----------------------------------------
   // Restart does not reach this, so missing blocks can still be filled in
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         LAST_GOB <= `DSR_EOP_GOB;
         LAST_MB  <= `DSR_EOP_MB;
      end
      else if (CE && MB_SENT)
      begin
         LAST_GOB <= MB_GOB;
         LAST_MB  <= MB_NUM;
      end
   end

   // ----------------------------------------
   // Snapshot freeze timers
   // ----------------------------------------
   logic [5:0] cfrz_q;
   logic [5:0] pfrz_q;
   logic       cnt_frz;
   logic       pic_frz;
   logic       cnt_rd_end;
   logic       pic_rd_end;

   assign cnt_rd_end = rd_end && (rd_adr_q >= `DSR_ADR_CNT_LO) && (rd_adr_q <= `DSR_ADR_CNT_HI);
   assign pic_rd_end = rd_end && (rd_adr_q >= `DSR_ADR_TREF) && (rd_adr_q <= `DSR_ADR_PS2);
   // The edge that ends a read holds too, else the copy moves before the timer starts
   assign cnt_frz = (rd_act && in_cnt) || cnt_rd_end || (cfrz_q != '0);
   assign pic_frz = (rd_act && in_pic) || pic_rd_end || (pfrz_q != '0);

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         cfrz_q <= '0;
         pfrz_q <= '0;
      end
      else if (CE)
      begin
         if (cnt_rd_end)
         begin
            cfrz_q <= `DSR_FRZ_CYC;
         end
         else if (cfrz_q != '0)
         begin
            cfrz_q <= cfrz_q - 1'b1;
         end
         if (pic_rd_end)
         begin
            pfrz_q <= `DSR_FRZ_CYC;
         end
         else if (pfrz_q != '0)
         begin
            pfrz_q <= pfrz_q - 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Event counters, master and visible copy
   // ----------------------------------------
   logic [CNT_W-1:0] cnt_m_q [`DSR_NUM_CNT];
   logic [CNT_W-1:0] cnt_s_q [`DSR_NUM_CNT];

   for (genvar i = 0; i < `DSR_NUM_CNT; i++)
   begin : g_cnt
      logic clr;
      assign clr = (i == `DSR_LOCK_IDX) ? lclr_q : oclr_q;

      always_ff @(posedge CLK or posedge RST)
      begin
         if (RST)
         begin
            cnt_m_q[i] <= '0;
            cnt_s_q[i] <= '0;
         end
         else if (CE)
         begin
            if (clr)
            begin
               cnt_m_q[i] <= '0;
            end
            else if (CNT_EV[i] && (cnt_m_q[i] != '1))
            begin
               cnt_m_q[i] <= cnt_m_q[i] + 1'b1;
            end
            if (!cnt_frz)
            begin
               cnt_s_q[i] <= cnt_m_q[i];
            end
         end
      end
   end

   // ----------------------------------------
   // Picture status, master and visible copy
   // ----------------------------------------
   dsr_pkg::dsr_pic_s pic_m_q;
   dsr_pkg::dsr_pic_s pic_s_q;
   logic [1:0]        ps_n_q;
   logic              rd_ps1;
   logic              rd_ps2;
   logic              st_ps1;
   logic              st_ps2;

   assign rd_ps1 = rd_end && (rd_adr_q == `DSR_ADR_PS1);
   assign rd_ps2 = rd_end && (rd_adr_q == `DSR_ADR_PS2);
   assign st_ps1 = PS_VLD && !PIC_LOAD && (ps_n_q == 2'h0);
   assign st_ps2 = PS_VLD && !PIC_LOAD && (ps_n_q == 2'h1);

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         pic_m_q <= '0;
         ps_n_q  <= '0;
      end
      else if (CE)
      begin
         if (PIC_LOAD)
         begin
            pic_m_q.tref  <= PIC_TREF;
            pic_m_q.flags <= PIC_FLAGS;
            pic_m_q.v1    <= 1'b0;
            pic_m_q.v2    <= 1'b0;
            ps_n_q        <= '0;
         end
         else
         begin
            if (RESTART)
            begin
               pic_m_q.v1 <= 1'b0;
               pic_m_q.v2 <= 1'b0;
            end
            else
            begin
               // A byte landing as the host clears the flag keeps its flag
               if (rd_ps1)
               begin
                  pic_m_q.v1 <= 1'b0;
               end
               if (rd_ps2)
               begin
                  pic_m_q.v2 <= 1'b0;
               end
            end
            if (st_ps1)
            begin
               pic_m_q.ps1 <= PS_BYTE;
               pic_m_q.v1  <= 1'b1;
            end
            if (st_ps2)
            begin
               pic_m_q.ps2 <= PS_BYTE;
               pic_m_q.v2  <= 1'b1;
            end
            if (PS_VLD && (ps_n_q != `DSR_PS_MAX))
            begin
               ps_n_q <= ps_n_q + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         pic_s_q <= '0;
      end
      else if (CE)
      begin
         if (!pic_frz)
         begin
            pic_s_q <= pic_m_q;
         end
         else
         begin
            if (rd_ps1 || RESTART)
            begin
               pic_s_q.v1 <= 1'b0;
            end
            if (rd_ps2 || RESTART)
            begin
               pic_s_q.v2 <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // Group spare queue
   // ----------------------------------------
   dsr_fifo_if gsq ();

   assign gsq.push      = GS_VLD;
   assign gsq.push_data = GS_BYTE;
   assign gsq.pop       = rd_end && (rd_adr_q == `DSR_ADR_GSQ);
   assign GS_FULL       = gsq.full;

   dsr_gspare_fifo #(
      .DEPTH (GS_DEPTH)
   ) u_gsq (
      .clk (CLK),
      .rst (RST),
      .ce  (CE),
      .q   (gsq.fifo)
   );

   // ----------------------------------------
   // Status registers
   // ----------------------------------------
   logic       pic_rdy_q;
   logic [3:0] stb_q;
   logic       rd_sta;

   assign rd_sta = rd_end && ((rd_adr_q == `DSR_ADR_STA) || (rd_adr_q == `DSR_ADR_STB));

   // New events win over a clearing read in the same cycle
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         pic_rdy_q <= 1'b0;
         stb_q     <= '0;
      end
      else if (CE)
      begin
         if (PIC_LOAD)
         begin
            pic_rdy_q <= 1'b1;
         end
         else if (rd_sta || RESTART)
         begin
            pic_rdy_q <= 1'b0;
         end
         if (RESTART)
         begin
            stb_q <= LOCK_EV;
         end
         else if (rd_end && (rd_adr_q == `DSR_ADR_STB))
         begin
            stb_q <= LOCK_EV;
         end
         else
         begin
            stb_q <= stb_q | LOCK_EV;
         end
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   logic [7:0] rd_mux;

   always_comb
   begin
      rd_mux = 8'h00;
      unique case (HA)
         `DSR_ADR_STA:
            rd_mux = {3'b000, pic_rdy_q, BUF_EMPTY, BUF_FULL, FRZ_ACTIVE, gsq.not_empty};
         `DSR_ADR_STB:
            rd_mux = {4'h0, stb_q};
         `DSR_ADR_CTA:
            rd_mux = CTRL_A;
         `DSR_ADR_CTB:
            rd_mux = CTRL_B;
         4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9:
            rd_mux = 8'(cnt_s_q[3'(HA - `DSR_ADR_CNT_LO)]);
         `DSR_ADR_TREF:
            rd_mux = pic_s_q.tref;
         `DSR_ADR_PINFO:
            rd_mux = {pic_s_q.v2, pic_s_q.v1, pic_s_q.flags, 2'b11};
         `DSR_ADR_PS1:
            rd_mux = pic_s_q.ps1;
         `DSR_ADR_PS2:
            rd_mux = pic_s_q.ps2;
         `DSR_ADR_GSQ:
            rd_mux = gsq.not_empty ? gsq.head : 8'h00;
         4'hF:
            rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         HD_OUT <= 8'h00;
      end
      else if (CE && rd_act)
      begin
         HD_OUT <= rd_mux;
      end
   end
endmodule : dsr_status_regs
`default_nettype wire

// [src/dsr_consts.svh]
// Offsets, field positions, reset values and counts for the
// demux status register bank.
// Assumes inclusion by bare name from files under src/.
`ifndef DSR_CONSTS_SVH
`define DSR_CONSTS_SVH
// ----------------------------------------
// Register offsets on HA[3:0]
// ----------------------------------------
`define DSR_ADR_STA    4'h0
`define DSR_ADR_STB    4'h1
`define DSR_ADR_CTA    4'h2
`define DSR_ADR_CTB    4'h3
`define DSR_ADR_CNT_LO 4'h4
`define DSR_ADR_CNT_HI 4'h9
`define DSR_ADR_TREF   4'hA
`define DSR_ADR_PINFO  4'hB
`define DSR_ADR_PS1    4'hC
`define DSR_ADR_PS2    4'hD
`define DSR_ADR_GSQ    4'hE
// ----------------------------------------
// Control bits and reset values
// ----------------------------------------
`define DSR_CTA_RST    8'h20
`define DSR_CTB_RST    8'h31
`define DSR_CTA_BCLR   6
`define DSR_CTA_RSTRT  7
`define DSR_CTB_LCLR   6
`define DSR_CTB_OCLR   7
`define DSR_LOCK_IDX   5
// ----------------------------------------
// Counts
// ----------------------------------------
`define DSR_FRZ_CYC    6'h20
`define DSR_NUM_CNT    6
`define DSR_PS_MAX     2'h2
`define DSR_GS_DEPTH   12
`define DSR_EOP_GOB    4'hC
`define DSR_EOP_MB     6'h21
`endif

// [src/dsr_pkg.sv]
// Types shared by the demux status register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package dsr_pkg;
   typedef logic [7:0] dsr_byte_t;
   typedef struct packed {
      dsr_byte_t  tref;
      logic [3:0] flags;
      dsr_byte_t  ps1;
      dsr_byte_t  ps2;
      logic       v1;
      logic       v2;
   } dsr_pic_s;
endpackage : dsr_pkg

// [src/dsr_fifo_if.sv]
// Link between the register bank and its spare byte queue.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface dsr_fifo_if;
   logic             push;
   dsr_pkg::dsr_byte_t push_data;
   logic             pop;
   dsr_pkg::dsr_byte_t head;
   logic             not_empty;
   logic             full;
   modport fifo (input push, push_data, pop, output head, not_empty, full);
   modport user (output push, push_data, pop, input head, not_empty, full);
endinterface : dsr_fifo_if
`default_nettype wire

// [src/dsr_gspare_fifo.sv]
// Flip-flop queue holding group spare bytes until the host reads them.
// Assumes one clock, asynchronous active-high reset and a clock enable.
`timescale 1ns/10ps
`default_nettype none
`include "dsr_consts.svh"
module dsr_gspare_fifo #(
   parameter int DEPTH = `DSR_GS_DEPTH
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   dsr_fifo_if.fifo  q
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [CW-1:0] FULLC = CW'(DEPTH);

   dsr_pkg::dsr_byte_t mem_q [DEPTH];
   logic [AW-1:0]      wr_q;
   logic [AW-1:0]      rd_q;
   logic [CW-1:0]      cnt_q;
   logic               do_push;
   logic               do_pop;

   // Bytes arriving while full are lost; the queue has no way to stall the line
   assign do_push     = q.push && (cnt_q != FULLC);
   assign do_pop      = q.pop && (cnt_q != '0);
   assign q.head      = mem_q[rd_q];
   assign q.not_empty = (cnt_q != '0);
   assign q.full      = (cnt_q == FULLC);

   always_ff @(posedge clk)
   begin
      if (ce && do_push)
      begin
         mem_q[wr_q] <= q.push_data;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else if (ce)
      begin
         if (do_push)
         begin
            wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
         end
         if (do_pop)
         begin
            rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
         end
         if (do_push && !do_pop)
         begin
            cnt_q <= cnt_q + 1'b1;
         end
         else if (do_pop && !do_push)
         begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule : dsr_gspare_fifo
`default_nettype wire

// [test/dsr_status_regs_props.sv]
// Port-level checks for the demux status register bank.
// Assumes one clock domain; the bench lowers CE only while it drives counter events.
`timescale 1ns/10ps
`default_nettype none
module dsr_status_regs_props #(
   parameter int CNT_W    = 8,
   parameter int GS_DEPTH = 12
) (
   input wire logic       CLK,
   input wire logic       RST,
   input wire logic       CE,
   input wire logic [3:0] HA,
   input wire logic [7:0] HD_IN,
   input wire logic [7:0] HD_OUT,
   input wire logic       HD_OE,
   input wire logic       CEN_N,
   input wire logic       RD_N,
   input wire logic       WR_N,
   input wire logic       MB_SENT,
   input wire logic [3:0] MB_GOB,
   input wire logic [5:0] MB_NUM,
   input wire logic [7:0] CTRL_A,
   input wire logic [7:0] CTRL_B,
   input wire logic       RESTART,
   input wire logic       BUF_PTR_CLR,
   input wire logic [3:0] LAST_GOB,
   input wire logic [5:0] LAST_MB
);
   // ---
   // Helper state
   // ---
   logic       wr_take;
   logic       wr_prev_q;
   logic       rd_prev_q;
   logic [7:0] hd_q;
   // A held write strobe is taken once, at its first edge only
   assign wr_take = CE && !CEN_N && !WR_N && !wr_prev_q;
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         wr_prev_q <= 1'b0;
         rd_prev_q <= 1'b0;
         hd_q      <= 8'h00;
      end
      else
      begin
         wr_prev_q <= !CEN_N && !WR_N;
         rd_prev_q <= !CEN_N && !RD_N;
         hd_q      <= HD_IN;
      end
   end
   // ---
   // Assertions
   // ---
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   sequence s_wr_a;
      wr_take && HA == 4'h2;
   endsequence
   sequence s_wr_b;
      wr_take && HA == 4'h3;
   endsequence
   a_reset_ctrl_val: assert property ($fell(RST) |-> CTRL_A == 8'h20 && CTRL_B == 8'h31)
      else $error("control registers not at reset value");
   a_reset_eop_pos: assert property ($fell(RST) |-> LAST_GOB == 4'hC && LAST_MB == 6'h21)
      else $error("last macroblock not at end of picture after reset");
   a_read_oe_map: assert property (HD_OE == (!CEN_N && !RD_N))
      else $error("read enable does not follow strobes");
   a_restart_pulse: assert property (s_wr_a ##0 HD_IN[7] |=> RESTART ##1 !RESTART)
      else $error("restart pulse missing or too long");
   a_bufclr_pulse: assert property (s_wr_a ##0 HD_IN[6] |=> BUF_PTR_CLR ##1 !BUF_PTR_CLR)
      else $error("buffer pointer clear pulse wrong");
   a_cta_load: assert property (s_wr_a |=> CTRL_A == {2'b00, hd_q[5:0]})
      else $error("control A not loaded");
   a_ctb_load: assert property (s_wr_b |=> CTRL_B == {2'b00, hd_q[5:0]})
      else $error("control B not loaded");
   a_ctrl_hold_idle: assert property (!wr_take |=> $stable(CTRL_A) && $stable(CTRL_B))
      else $error("control register changed without write");
   a_mb_track: assert property (MB_SENT |=> LAST_GOB == $past(MB_GOB) && LAST_MB == $past(MB_NUM))
      else $error("last macroblock not tracked");
   a_hd_hold: assert property (!(!CEN_N && !RD_N) && !rd_prev_q |-> $stable(HD_OUT))
      else $error("read data moved outside a read");
endmodule : dsr_status_regs_props
bind dsr_status_regs dsr_status_regs_props #(.CNT_W(CNT_W), .GS_DEPTH(GS_DEPTH)) u_props (
   .CLK(CLK), .RST(RST), .CE(CE), .HA(HA), .HD_IN(HD_IN), .HD_OUT(HD_OUT), .HD_OE(HD_OE),
   .CEN_N(CEN_N), .RD_N(RD_N), .WR_N(WR_N), .MB_SENT(MB_SENT), .MB_GOB(MB_GOB), .MB_NUM(MB_NUM),
   .CTRL_A(CTRL_A), .CTRL_B(CTRL_B), .RESTART(RESTART), .BUF_PTR_CLR(BUF_PTR_CLR),
   .LAST_GOB(LAST_GOB), .LAST_MB(LAST_MB));
`default_nettype wire

// [test/dsr_host_model.sv]
// System controller model on the byte-wide host bus.
// Assumes the bank's clock; changes the bus at falling edges only.
`timescale 1ns/10ps
`default_nettype none
module dsr_host_model (
   input  wire logic       clk,
   input  wire logic [7:0] hd_out,
   output var  logic [3:0] ha,
   output var  logic [7:0] hd_in,
   output var  logic       cen_n,
   output var  logic       rd_n,
   output var  logic       wr_n
);
   initial
   begin
      ha    = 4'hF;
      hd_in = 8'h00;
      cen_n = 1'b1;
      rd_n  = 1'b1;
      wr_n  = 1'b1;
   end
   // ---
   // Bus cycles
   // ---
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk);
      ha    = a;
      hd_in = d;
      cen_n = 1'b0;
      wr_n  = 1'b0;
      @(negedge clk);
      cen_n = 1'b1;
      wr_n  = 1'b1;
      // Released data shows the inverse so a stale byte is never reused
      hd_in = ~d;
      @(negedge clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge clk);
      ha    = a;
      cen_n = 1'b0;
      rd_n  = 1'b0;
      repeat (2) @(negedge clk);
      d     = hd_out;
      cen_n = 1'b1;
      rd_n  = 1'b1;
      @(negedge clk);
   endtask : rd
   task automatic full_restart;
      wr(4'h2, 8'hE0);
   endtask : full_restart
endmodule : dsr_host_model
`default_nettype wire

// [test/dsr_status_regs_tb_top.sv]
// Self-checking bench for the demux status register bank.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module dsr_status_regs_tb_top;
   logic       CLK = 1'b0;
   logic       RST, CE, CEN_N, RD_N, WR_N, HD_OE, PIC_LOAD, PS_VLD, GS_VLD;
   logic       FRZ_ACTIVE, BUF_FULL, BUF_EMPTY, MB_SENT, RESTART, BUF_PTR_CLR, GS_FULL;
   logic [3:0] HA, PIC_FLAGS, LOCK_EV, MB_GOB, LAST_GOB;
   logic [5:0] CNT_EV, MB_NUM, LAST_MB;
   logic [7:0] HD_IN, HD_OUT, PIC_TREF, PS_BYTE, GS_BYTE, CTRL_A, CTRL_B, v;
   int         num_errors = 0;
   int         tests_run = 0;
   int         n_rst = 0;
   int         n_clr = 0;
   always #12.5 CLK = ~CLK;
   dsr_status_regs DUT (.*);
   dsr_host_model host (.clk(CLK), .hd_out(HD_OUT), .ha(HA), .hd_in(HD_IN), .cen_n(CEN_N),
                        .rd_n(RD_N), .wr_n(WR_N));
   always @(posedge CLK)
   begin
      n_rst += (RESTART === 1'b1);
      n_clr += (BUF_PTR_CLR === 1'b1);
   end
   // ---
   // Tasks
   // ---
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic rc(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      check(d, exp);
   endtask : rc
   task automatic ev(input int k, input int n);
      repeat (n)
      begin
         @(negedge CLK);
         CNT_EV[k] = 1'b1;
         @(negedge CLK);
         CNT_EV = 6'h00;
      end
   endtask : ev
   task automatic fire(input logic [3:0] m);
      @(negedge CLK);
      {MB_SENT, GS_VLD, PS_VLD, PIC_LOAD} = m;
      @(negedge CLK);
      {MB_SENT, GS_VLD, PS_VLD, PIC_LOAD} = 4'h0;
   endtask : fire
   // Longer than the 32-clock snapshot hold
   task automatic settle;
      repeat (40) @(negedge CLK);
   endtask : settle
   task automatic wrap_up;
      if (num_errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up
   // ---
   // Main sequence
   // ---
   initial
   begin
      #500000;
      num_errors++;
      wrap_up();
   end
   initial
   begin
      RST = 1'b1;
      CE = 1'b1;
      CNT_EV = 6'h00;
      {MB_SENT, GS_VLD, PS_VLD, PIC_LOAD} = 4'h0;
      {PIC_TREF, PS_BYTE, GS_BYTE} = 24'h000000;
      {FRZ_ACTIVE, BUF_FULL, BUF_EMPTY} = 3'h1;
      {PIC_FLAGS, LOCK_EV, MB_GOB, MB_NUM} = 18'h00000;
      repeat (16) @(negedge CLK);
      RST = 1'b0;
      check(CTRL_A, 8'h20);
      check(CTRL_B, 8'h31);
      check({4'h0, LAST_GOB}, 8'h0C);
      check({2'h0, LAST_MB}, 8'h21);
      rc(4'h9, 8'h00);
      // Let the snapshot taken by that read run out first
      settle();
      ev(0, 3);
      ev(1, 2);
      ev(5, 1);
      rc(4'h4, 8'h03);
      ev(0, 1);
      rc(4'h5, 8'h02);
      rc(4'h4, 8'h03);
      settle();
      rc(4'h4, 8'h04);
      rc(4'h9, 8'h01);
      ev(5, 300);
      settle();
      rc(4'h9, 8'hFF);
      host.wr(4'h3, 8'h71);
      settle();
      check(CTRL_B, 8'h31);
      rc(4'h9, 8'h00);
      rc(4'h4, 8'h04);
      host.wr(4'h3, 8'hB1);
      settle();
      rc(4'h4, 8'h00);
      rc(4'h5, 8'h00);
      PIC_TREF = 8'h5A;
      PIC_FLAGS = 4'hA;
      fire(4'h1);
      for (int i = 1; i < 4; i++)
      begin
         PS_BYTE = 8'(i * 17);
         fire(4'h2);
      end
      rc(4'hB, 8'hEB);
      rc(4'hC, 8'h11);
      rc(4'hD, 8'h22);
      settle();
      rc(4'hB, 8'h2B);
      rc(4'hA, 8'h5A);
      PIC_TREF = 8'h66;
      fire(4'h1);
      rc(4'hA, 8'h5A);
      settle();
      rc(4'hA, 8'h66);
      for (int i = 0; i < 13; i++)
      begin
         GS_BYTE = 8'h80 + 8'(i);
         fire(4'h4);
      end
      check({7'h00, GS_FULL}, 8'h01);
      host.rd(4'h0, v);
      check(v & 8'h01, 8'h01);
      for (int i = 0; i < 12; i++)
         rc(4'hE, 8'h80 + 8'(i));
      rc(4'hE, 8'h00);
      host.rd(4'h0, v);
      check(v & 8'h01, 8'h00);
      MB_GOB = 4'h3;
      MB_NUM = 6'h07;
      fire(4'h8);
      LOCK_EV = 4'h4;
      @(negedge CLK);
      LOCK_EV = 4'h0;
      host.full_restart();
      check(CTRL_A, 8'h20);
      check({4'h0, LAST_GOB}, 8'h03);
      check({2'h0, LAST_MB}, 8'h07);
      rc(4'h1, 8'h00);
      host.wr(4'h2, 8'h60);
      check(8'(n_rst), 8'h01);
      check(8'(n_clr), 8'h02);
      ev(0, 2);
      // Events while the clock enable is low must not count
      CE = 1'b0;
      ev(0, 3);
      CE = 1'b1;
      settle();
      rc(4'h4, 8'h02);
      RST = 1'b1;
      @(negedge CLK);
      RST = 1'b0;
      check({4'h0, LAST_GOB}, 8'h0C);
      rc(4'h4, 8'h00);
      wrap_up();
   end
endmodule : dsr_status_regs_tb_top
`default_nettype wire
